// *** hdcr_consts.svh ***
// Constants of the haptic drive control register group.
// Assumes inclusion by bare name; holds macros only.
`ifndef HDCR_CONSTS_SVH
`define HDCR_CONSTS_SVH

// ****
// Register indices (byte address is four times index)
// ****
`define HDCR_IDX_BOOST_CFG 6'h13
`define HDCR_IDX_IMP_CTL 6'h16
`define HDCR_IDX_LOCK_FAULT 6'h17
`define HDCR_IDX_KP_HIGH 6'h1C
`define HDCR_IDX_KP_LOW 6'h1D
`define HDCR_IDX_KI_HIGH 6'h1E
`define HDCR_IDX_KI_LOW 6'h1F
`define HDCR_IDX_BRAKE_PAUSE 6'h20
`define HDCR_IDX_PLAY_CTL 6'h22
`define HDCR_IDX_DRIVE_LEVEL 6'h23
`define HDCR_IDX_SEQ_CFG 6'h24
`define HDCR_IDX_IRQ_STATUS 6'h30
`define HDCR_IDX_IRQ_MASK 6'h31
`define HDCR_IDX_LIVE_STATE 6'h32

// ****
// Field positions
// ****
`define HDCR_BIT_BOOST 2
`define HDCR_BIT_HOLD 7
`define HDCR_BIT_INHIBIT 6
`define HDCR_BIT_START 4
`define HDCR_BIT_STANDBY 3
`define HDCR_BIT_TIMEBASE 2

// ****
// Reset values and writable masks
// ****
`define HDCR_RST_BOOST_CFG 8'h04
`define HDCR_RST_IMP_CTL 8'h40
`define HDCR_RST_LOCK_FAULT 8'h81
`define HDCR_RST_KP_HIGH 8'h09
`define HDCR_RST_KP_LOW 8'h00
`define HDCR_RST_KI_HIGH 8'h04
`define HDCR_RST_KI_LOW 8'hD0
`define HDCR_RST_BRAKE_PAUSE 8'h53
`define HDCR_MASK_BOOST_CFG 8'h04
`define HDCR_MASK_IMP_CTL 8'hC0
`define HDCR_MASK_BRAKE_PAUSE 8'h7F
`define HDCR_MASK_PLAY_CTL 8'h1F
`define HDCR_MASK_SEQ_CFG 8'h04
`define HDCR_MASK_IRQ 8'h07

// ****
// Back-EMF thresholds in 0.1 mV units, frame times in us
// ****
`define HDCR_BEMF_TH1 10'h031
`define HDCR_BEMF_TH2 10'h117
`define HDCR_BEMF_TH3 10'h1F3
`define HDCR_FRAME_1360US 17'h00550
`define HDCR_FRAME_5440US 17'h01540
`define HDCR_FRAME_21760US 17'h05500
`define HDCR_FRAME_43520US 17'h0AA00
`define HDCR_FRAME_87040US 17'h15400

`endif

// *** hdcr_pkg.sv ***
// Types shared by the haptic drive control register group.
// Assumes hdcr_consts.svh supplies the numeric constants.
package hdcr_pkg;

    // Operating mode select encodings
    typedef enum logic [2:0] {
        HDCR_MODE_INACTIVE = 3'h0,
        HDCR_MODE_DIRECT = 3'h1,
        HDCR_MODE_PWM = 3'h2,
        HDCR_MODE_REG_TRIG = 3'h3,
        HDCR_MODE_EDGE_TRIG = 3'h4
    } hdcr_mode_t;

    // Playback sequencer states
    typedef enum logic [1:0] {
        HDCR_ST_IDLE = 2'h0,
        HDCR_ST_STANDBY = 2'h1,
        HDCR_ST_PLAYING = 2'h2
    } hdcr_state_t;

    // Tracking loop gain pair; each gain goes live on its own low byte write
    typedef struct packed {
        logic [15:0] proportional;
        logic [15:0] integral;
    } hdcr_gains_t;

    // Measurements fed in from the drive core
    typedef struct packed {
        logic [7:0] tracking_error;
        logic [9:0] bemf_level;
        logic braking;
        logic [2:0] brake_level;
        logic [3:0] track_level;
        logic playback_done;
    } hdcr_sense_t;

endpackage : hdcr_pkg

// *** hdcr_regs.sv ***
// Haptic drive control register group with Avalon-MM slave port.
// Assumes one 10 MHz clock, synchronous active-high reset and
// sense inputs synchronous to that clock.
//
// Notes on behaviour
// - Hold bit stops all factor updates
// - Inhibit bit stops factor updates during playback
// - Locked when error below four times limit
// - Back-EMF fault below selected threshold
// - Proportional gain from byte pair, resets 0x900
// - Integral gain from byte pair, resets 0x4D0
// - Braking stops drive at selected threshold
// - Tracking pauses at selected threshold
// - Start bit starts playback, zero during playback returns idle
// - Standby select picks state after playback
// - Three-bit field selects operating mode
// - Direct mode uses signed drive level
// - Boost forces negative drive levels to zero
// - Timebase bit selects frame time steps
// - Boost enable bit, resets enabled
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
`include "hdcr_consts.svh"

module hdcr_regs (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire hdcr_pkg::hdcr_sense_t sense_in,
    output hdcr_pkg::hdcr_gains_t gains_out,
    output logic factor_update_en_out,
    output logic freq_locked_out,
    output logic bemf_fault_out,
    output logic brake_stop_out,
    output logic tracking_pause_out,
    output hdcr_pkg::hdcr_mode_t mode_out,
    output hdcr_pkg::hdcr_state_t state_out,
    output logic signed [7:0] drive_scale_out,
    output logic [16:0] frame_time0_us_out,
    output logic [16:0] frame_time3_us_out,
    output logic irq_out
);

    // ****
    // Helper functions
    // ****

    // Merge masked write data into a register value
    function automatic logic [7:0] merge_w(input logic [7:0] old_v,
            input logic [7:0] wd, input logic [7:0] mask);
        merge_w = (old_v & ~mask) | (wd & mask);
    endfunction : merge_w

    // Back-EMF threshold for a two-bit select code
    function automatic logic [9:0] bemf_th(input logic [1:0] sel);
        case (sel)
            2'h1: bemf_th = `HDCR_BEMF_TH1;
            2'h2: bemf_th = `HDCR_BEMF_TH2;
            2'h3: bemf_th = `HDCR_BEMF_TH3;
            default: bemf_th = 10'h000;
        endcase
    endfunction : bemf_th

    // ****
    // Bus handshake
    // ****
    logic ack_reg; // One-cycle accept strobe
    logic req; // Live request
    logic wr_go; // Write accepted this edge
    logic [5:0] idx; // Register index from byte address
    logic [7:0] wd; // Low byte of write data

    assign req = avs_read_in | avs_write_in;
    assign idx = avs_address_in[7:2];
    assign wd = avs_writedata_in[7:0];
    // Byte lane 0 must be enabled, otherwise the write changes nothing
    assign wr_go = avs_write_in & ack_reg & avs_byteenable_in[0];
    // Every access waits exactly one cycle; keeps decode registered
    assign avs_waitrequest_out = req & ~ack_reg;

    // Accept strobe follows one cycle after request appears
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req & ~ack_reg;
        end
    end

    // ****
    // Configuration registers
    // ****
    logic [7:0] boost_cfg_reg; // Boost enable word
    logic [7:0] imp_ctl_reg; // Impedance tracking control
    logic [7:0] lock_fault_reg; // Lock and fault limits
    logic [7:0] kp_high_reg; // Staged proportional high byte
    logic [7:0] kp_low_reg; // Proportional low byte
    logic [7:0] ki_high_reg; // Staged integral high byte
    logic [7:0] ki_low_reg; // Integral low byte
    logic [7:0] brake_pause_reg; // Brake and pause thresholds
    logic [7:0] play_ctl_reg; // Playback and mode control
    logic [7:0] drive_level_reg; // Direct drive level
    logic [7:0] seq_cfg_reg; // Sequence config one
    logic [7:0] irq_status_reg; // Sticky event flags
    logic [7:0] irq_mask_reg; // Event enables
    logic start_clear; // Hardware clears start bit

    // Plain read-write registers; undefined bits masked off
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            boost_cfg_reg <= `HDCR_RST_BOOST_CFG;
            imp_ctl_reg <= `HDCR_RST_IMP_CTL;
            lock_fault_reg <= `HDCR_RST_LOCK_FAULT;
            brake_pause_reg <= `HDCR_RST_BRAKE_PAUSE;
            drive_level_reg <= 8'h00;
            seq_cfg_reg <= 8'h00;
            irq_mask_reg <= 8'h00;
        end else if (wr_go) begin
            case (idx)
                `HDCR_IDX_BOOST_CFG: boost_cfg_reg <=
                    merge_w(boost_cfg_reg, wd, `HDCR_MASK_BOOST_CFG);
                `HDCR_IDX_IMP_CTL: imp_ctl_reg <=
                    merge_w(imp_ctl_reg, wd, `HDCR_MASK_IMP_CTL);
                `HDCR_IDX_LOCK_FAULT: lock_fault_reg <= wd;
                `HDCR_IDX_BRAKE_PAUSE: brake_pause_reg <=
                    merge_w(brake_pause_reg, wd, `HDCR_MASK_BRAKE_PAUSE);
                `HDCR_IDX_DRIVE_LEVEL: drive_level_reg <= wd;
                `HDCR_IDX_SEQ_CFG: seq_cfg_reg <=
                    merge_w(seq_cfg_reg, wd, `HDCR_MASK_SEQ_CFG);
                `HDCR_IDX_IRQ_MASK: irq_mask_reg <=
                    merge_w(irq_mask_reg, wd, `HDCR_MASK_IRQ);
                default: ;
            endcase
        end
    end

    // Playback control; completion clears start, a write still wins
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            play_ctl_reg <= 8'h00;
        end else if (wr_go && idx == `HDCR_IDX_PLAY_CTL) begin
            play_ctl_reg <= merge_w(play_ctl_reg, wd,
                `HDCR_MASK_PLAY_CTL);
        end else if (start_clear) begin
            play_ctl_reg[`HDCR_BIT_START] <= 1'b0;
        end
    end

    // ****
    // Gain byte pairs
    // ****
    // High bytes are staged; the pair goes live on the low byte
    // write so the loop never sees half a value
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            kp_high_reg <= `HDCR_RST_KP_HIGH;
            kp_low_reg <= `HDCR_RST_KP_LOW;
            ki_high_reg <= `HDCR_RST_KI_HIGH;
            ki_low_reg <= `HDCR_RST_KI_LOW;
            gains_out <= {`HDCR_RST_KP_HIGH, `HDCR_RST_KP_LOW,
                `HDCR_RST_KI_HIGH, `HDCR_RST_KI_LOW};
        end else if (wr_go) begin
            case (idx)
                `HDCR_IDX_KP_HIGH: kp_high_reg <= wd;
                `HDCR_IDX_KP_LOW: begin
                    kp_low_reg <= wd;
                    gains_out.proportional <= {kp_high_reg, wd};
                end
                `HDCR_IDX_KI_HIGH: ki_high_reg <= wd;
                `HDCR_IDX_KI_LOW: begin
                    ki_low_reg <= wd;
                    gains_out.integral <= {ki_high_reg, wd};
                end
                default: ;
            endcase
        end
    end

    // ****
    // Playback sequencer
    // ****
    hdcr_pkg::hdcr_state_t state_reg; // Current state
    hdcr_pkg::hdcr_state_t state_next; // Next state
    logic start_bit; // Live start bit

    assign start_bit = play_ctl_reg[`HDCR_BIT_START];
    assign start_clear = (state_reg == hdcr_pkg::HDCR_ST_PLAYING) &
        sense_in.playback_done;

    // Next-state decode for playback
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            hdcr_pkg::HDCR_ST_IDLE,
            hdcr_pkg::HDCR_ST_STANDBY: begin
                if (start_bit) begin
                    state_next = hdcr_pkg::HDCR_ST_PLAYING;
                end
            end
            hdcr_pkg::HDCR_ST_PLAYING: begin
                if (!start_bit) begin
                    state_next = hdcr_pkg::HDCR_ST_IDLE;
                end else if (sense_in.playback_done) begin
                    // Post-playback state by standby select
                    state_next = play_ctl_reg[`HDCR_BIT_STANDBY] ?
                        hdcr_pkg::HDCR_ST_STANDBY :
                        hdcr_pkg::HDCR_ST_IDLE;
                end
            end
            default: state_next = hdcr_pkg::HDCR_ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_reg <= hdcr_pkg::HDCR_ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****
    // Derived control outputs
    // ****
    logic lock_now; // Lock comparison
    logic fault_now; // Back-EMF fault comparison
    logic [1:0] fsel; // Back-EMF select code

    assign fsel = lock_fault_reg[1:0];
    // Error compared against limit times four
    assign lock_now = {2'b00, sense_in.tracking_error} <
        {lock_fault_reg[7:2], 2'b00};
    // Code zero disables the
    assign fault_now = (fsel != 2'h0) &
        (sense_in.bemf_level < bemf_th(fsel));

    // Registered control outputs
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            factor_update_en_out <= 1'b0;
            freq_locked_out <= 1'b0;
            bemf_fault_out <= 1'b0;
            brake_stop_out <= 1'b0;
            tracking_pause_out <= 1'b0;
            mode_out <= hdcr_pkg::HDCR_MODE_INACTIVE;
            state_out <= hdcr_pkg::HDCR_ST_IDLE;
        end else begin
            // Hold stops all updates, inhibit only while playing
            factor_update_en_out <= ~imp_ctl_reg[`HDCR_BIT_HOLD] &
                ~(imp_ctl_reg[`HDCR_BIT_INHIBIT] &
                (state_reg == hdcr_pkg::HDCR_ST_PLAYING));
            freq_locked_out <= lock_now;
            bemf_fault_out <= fault_now;
            // Drive stops once braking level reaches threshold
            brake_stop_out <= sense_in.braking &
                (sense_in.brake_level <= brake_pause_reg[6:4]);
            tracking_pause_out <=
                (sense_in.track_level <= brake_pause_reg[3:0]);
            // Unknown codes fall back to inactive
            case (play_ctl_reg[2:0])
                3'h1: mode_out <= hdcr_pkg::HDCR_MODE_DIRECT;
                3'h2: mode_out <= hdcr_pkg::HDCR_MODE_PWM;
                3'h3: mode_out <= hdcr_pkg::HDCR_MODE_REG_TRIG;
                3'h4: mode_out <= hdcr_pkg::HDCR_MODE_EDGE_TRIG;
                default: mode_out <= hdcr_pkg::HDCR_MODE_INACTIVE;
            endcase
            state_out <= state_next;
        end
    end

    // Drive level scaling; zero outside direct mode
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            drive_scale_out <= 8'sh00;
        end else if (play_ctl_reg[2:0] != 3'h1) begin
            drive_scale_out <= 8'sh00;
        end else if (boost_cfg_reg[`HDCR_BIT_BOOST] &&
                drive_level_reg[7]) begin
            drive_scale_out <= 8'sh00;
        end else begin
            drive_scale_out <= $signed(drive_level_reg);
        end
    end

    // Frame time range by timebase; step 3 is 16 times step 0 with timebase clear, 32 times when set;
    // steps 1 and 2 are derived downstream
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            frame_time0_us_out <= `HDCR_FRAME_5440US;
            frame_time3_us_out <= `HDCR_FRAME_87040US;
        end else if (seq_cfg_reg[`HDCR_BIT_TIMEBASE]) begin
            frame_time0_us_out <= `HDCR_FRAME_1360US;
            frame_time3_us_out <= `HDCR_FRAME_43520US;
        end else begin
            frame_time0_us_out <= `HDCR_FRAME_5440US;
            frame_time3_us_out <= `HDCR_FRAME_87040US;
        end
    end

    // ****
    // Interrupt status
    // ****
    logic [7:0] irq_events; // Events this cycle
    logic [7:0] irq_clear; // Write-one-to-clear mask

    // Bit 0 fault rise, bit 1 playback done, bit 2 lock gained
    assign irq_events = {5'h00, lock_now & ~freq_locked_out,
        start_clear, fault_now & ~bemf_fault_out};
    assign irq_clear = (wr_go && idx == `HDCR_IDX_IRQ_STATUS) ?
        (wd & `HDCR_MASK_IRQ) : 8'h00;

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            irq_status_reg <= 8'h00;
            irq_out <= 1'b0;
        end else begin
            irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_events;
            irq_out <= |(((irq_status_reg & ~irq_clear) | irq_events) &
                irq_mask_reg);
        end
    end

    // ****
    // Read data
    // ****
    logic [7:0] rd_byte; // Selected register byte

    // Read mux; unmapped offsets return zero
    always_comb begin
        case (idx)
            `HDCR_IDX_BOOST_CFG: rd_byte = boost_cfg_reg;
            `HDCR_IDX_IMP_CTL: rd_byte = imp_ctl_reg;
            `HDCR_IDX_LOCK_FAULT: rd_byte = lock_fault_reg;
            `HDCR_IDX_KP_HIGH: rd_byte = kp_high_reg;
            `HDCR_IDX_KP_LOW: rd_byte = kp_low_reg;
            `HDCR_IDX_KI_HIGH: rd_byte = ki_high_reg;
            `HDCR_IDX_KI_LOW: rd_byte = ki_low_reg;
            `HDCR_IDX_BRAKE_PAUSE: rd_byte = brake_pause_reg;
            `HDCR_IDX_PLAY_CTL: rd_byte = play_ctl_reg;
            `HDCR_IDX_DRIVE_LEVEL: rd_byte = drive_level_reg;
            `HDCR_IDX_SEQ_CFG: rd_byte = seq_cfg_reg;
            `HDCR_IDX_IRQ_STATUS: rd_byte = irq_status_reg;
            `HDCR_IDX_IRQ_MASK: rd_byte = irq_mask_reg;
            `HDCR_IDX_LIVE_STATE: rd_byte = {3'h0, freq_locked_out,
                bemf_fault_out, 1'b0, state_reg};
            default: rd_byte = 8'h00;
        endcase
    end

    // Read data registered on the edge that raises ack_reg, one before the accept edge; upper bytes zero
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            avs_readdata_out <= 32'h00000000;
        end else if (avs_read_in && !ack_reg) begin
            avs_readdata_out <= {24'h000000, rd_byte};
        end
    end

endmodule : hdcr_regs

// *** hdcr_props.sv ***
// Concurrent checks on the haptic drive control register ports.
// Assumes a bind onto hdcr_regs; one clock, synchronous reset.
`timescale 1ns/1ps
module hdcr_props (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [7:0] avs_address_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire hdcr_pkg::hdcr_sense_t sense_in,
    input wire hdcr_pkg::hdcr_gains_t gains_out,
    input wire logic freq_locked_out,
    input wire logic bemf_fault_out,
    input wire logic brake_stop_out,
    input wire hdcr_pkg::hdcr_mode_t mode_out,
    input wire hdcr_pkg::hdcr_state_t state_out,
    input wire logic signed [7:0] drive_scale_out,
    input wire logic [16:0] frame_time0_us_out,
    input wire logic [16:0] frame_time3_us_out
);
    // ****
    // Clocking, helpers and checks
    // ****
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // Accepted write to a gain low byte (index 0x1D or 0x1F)
    wire logic low_wr = avs_write_in && !avs_waitrequest_out &&
        avs_address_in[7:4] == 4'h7 && avs_address_in[2];
    property p_lock;
        freq_locked_out |-> $past(sense_in.tracking_error) < 8'hFC;
    endproperty
    a_lock: assert property (p_lock) else $error("lock bad");
    property p_emf;
        bemf_fault_out |-> $past(sense_in.bemf_level) < 10'h1F3;
    endproperty
    a_emf: assert property (p_emf) else $error("fault bad");
    property p_brk; brake_stop_out |-> $past(sense_in.braking); endproperty
    a_brk: assert property (p_brk) else $error("stop bad");
    // A same-cycle write wins only over the start clear, not the state change; write cycles are still skipped
    property p_end;
        state_out == hdcr_pkg::HDCR_ST_PLAYING && sense_in.playback_done
            && !avs_write_in |=> state_out != hdcr_pkg::HDCR_ST_PLAYING;
    endproperty
    a_end: assert property (p_end) else $error("end bad");
    property p_drv;
        drive_scale_out != 8'h00 |-> mode_out == hdcr_pkg::HDCR_MODE_DIRECT
            || $past(mode_out) == hdcr_pkg::HDCR_MODE_DIRECT;
    endproperty
    a_drv: assert property (p_drv) else $error("scale bad");
    property p_frm;
        frame_time0_us_out == 17'h01540 && frame_time3_us_out == 17'h15400
        || frame_time0_us_out == 17'h00550 && frame_time3_us_out == 17'h0AA00;
    endproperty
    a_frm: assert property (p_frm) else $error("frame bad");
    property p_rdz; avs_readdata_out[31:8] == 24'h000000; endproperty
    a_rdz: assert property (p_rdz) else $error("high bits");
    // Gains may move only one or two edges after a low byte write
    property p_gain;
        $changed(gains_out) |-> $past(low_wr) || $past(low_wr, 2);
    endproperty
    a_gain: assert property (p_gain) else $error("gain bad");
    c_stby: cover property (state_out == hdcr_pkg::HDCR_ST_STANDBY);
    c_emf: cover property (bemf_fault_out);
    c_neg: cover property (drive_scale_out[7]);
endmodule : hdcr_props

// *** hdcr_host.sv ***
// Host software stand-in: an Avalon-MM master for register cycles.
// Assumes the slave shares its clock and answers on waitrequest.
`timescale 1ns/1ps
module hdcr_host (
    input wire logic clk_in,
    input wire logic [31:0] avs_readdata_in,
    input wire logic avs_waitrequest_in,
    output logic [7:0] avs_address_out,
    output logic avs_read_out,
    output logic avs_write_out,
    output logic [31:0] avs_writedata_out,
    output logic [3:0] avs_byteenable_out
);
    // ****
    // Bus idle from time zero
    // ****
    initial begin
        avs_address_out <= 8'h00;
        avs_read_out <= 1'b0;
        avs_write_out <= 1'b0;
        avs_writedata_out <= 32'h00000000;
        avs_byteenable_out <= 4'h0;
    end
    // One cycle, held until waitrequest is seen low at an edge;
    // no cycle limit here, the bench timeout cuts a hang
    task automatic xfer(input logic w, input logic [5:0] idx,
        input logic [7:0] d, input logic [3:0] be, output logic [31:0] q);
        @(posedge clk_in);
        avs_address_out <= {idx, 2'h0};
        avs_writedata_out <= {24'h000000, d};
        avs_byteenable_out <= be;
        avs_write_out <= w;
        avs_read_out <= !w;
        do @(posedge clk_in); while (avs_waitrequest_in !== 1'b0);
        q = avs_readdata_in;
        avs_read_out <= 1'b0;
        avs_write_out <= 1'b0;
    endtask : xfer
endmodule : hdcr_host

// *** haptic_drive_control_regs_tb.sv ***
// Self-checking bench for the haptic drive control register group.
// Assumes hdcr_regs, hdcr_props and hdcr_host are compiled first.
`timescale 1ns/1ps
module haptic_drive_control_regs_tb;
    // ****
    // Signals named as design ports
    // ****
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] avs_address_in;
    logic avs_read_in, avs_write_in, avs_waitrequest_out;
    logic [31:0] avs_writedata_in, avs_readdata_out, q;
    logic [3:0] avs_byteenable_in;
    // Quiet sense: no fault or lock event after reset
    hdcr_pkg::hdcr_sense_t sense_in = {8'hFF, 10'h3FF, 9'h000};
    hdcr_pkg::hdcr_gains_t gains_out;
    logic factor_update_en_out, freq_locked_out, bemf_fault_out;
    logic brake_stop_out, tracking_pause_out, irq_out;
    hdcr_pkg::hdcr_mode_t mode_out;
    hdcr_pkg::hdcr_state_t state_out;
    logic signed [7:0] drive_scale_out;
    logic [16:0] frame_time0_us_out, frame_time3_us_out;
    logic [31:0] seed = 32'h59DD0725;
    logic [5:0] hi;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;
    // Index, reset value, writable bits; the last index is unmapped
    localparam logic [5:0] IDX [14] = '{6'h13, 6'h16, 6'h17, 6'h1C, 6'h1D,
        6'h1E, 6'h1F, 6'h20, 6'h22, 6'h23, 6'h24, 6'h30, 6'h31, 6'h3F};
    localparam logic [7:0] RSTV [14] = '{8'h04, 8'h40, 8'h81, 8'h09, 8'h00,
        8'h04, 8'hD0, 8'h53, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] MSK [14] = '{8'h04, 8'hC0, 8'hFF, 8'hFF, 8'hFF,
        8'hFF, 8'hFF, 8'h7F, 8'h1F, 8'hFF, 8'h04, 8'h07, 8'h07, 8'h00};
    localparam logic [9:0] TH [4] = '{10'h3FF, 10'h031, 10'h117, 10'h1F3};
    // Boost, mode, drive level, expected scale
    localparam logic [19:0] DRV [5] = '{20'h98000, 20'h18080, 20'h97F7F,
        20'h1FFFF, 20'h37F00};
    hdcr_regs uut (.*);
    hdcr_host u_host (.clk_in(clk_in), .avs_readdata_in(avs_readdata_out),
        .avs_waitrequest_in(avs_waitrequest_out),
        .avs_address_out(avs_address_in), .avs_read_out(avs_read_in),
        .avs_write_out(avs_write_in), .avs_writedata_out(avs_writedata_in),
        .avs_byteenable_out(avs_byteenable_in));
    initial forever #50 clk_in = ~clk_in;
    // Hang guard, far above the few hundred cycles needed
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            complete_run();
        end
    end
    task automatic complete_run();
        if (failures == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [5:0] i, input logic [7:0] d);
        u_host.xfer(1'b1, i, d, 4'hF, q);
    endtask : wr
    task automatic rd(input logic [5:0] i);
        u_host.xfer(1'b0, i, 8'h00, 4'hF, q);
    endtask : rd
    // Registered outputs land one edge after their cause
    task automatic settle();
        repeat (2) @(negedge clk_in);
    endtask : settle
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [15:0] gsel(input int p);
        return p ? gains_out.integral : gains_out.proportional;
    endfunction : gsel
    initial begin
        repeat (20) @(posedge clk_in);
        rst_in <= 1'b0;
        chk(gains_out, 32'h090004D0);
        for (int k = 0; k < 14; k++) begin
            rd(IDX[k]);
            chk(q, RSTV[k]);
        end
        // Random data, a write without byte lane 0 first
        for (int k = 0; k < 14; k++) begin
            if (IDX[k] == 6'h22 || IDX[k] == 6'h30) continue;
            seed = lfsr(seed);
            u_host.xfer(1'b1, IDX[k], ~seed[7:0], 4'h0, q);
            wr(IDX[k], seed[7:0]);
            rd(IDX[k]);
            chk(q, seed[7:0] & MSK[k]);
        end
        for (int p = 0; p < 2; p++) begin
            seed = lfsr(seed);
            hi = p ? 6'h1E : 6'h1C;
            wr(hi, seed[31:24]);
            wr(hi + 6'h01, seed[23:16]);
            wr(hi, seed[15:8]);
            settle();
            chk(gsel(p), seed[31:16]);
            wr(hi + 6'h01, seed[7:0]);
            settle();
            chk(gsel(p), seed[15:0]);
        end
        for (int s = 0; s < 4; s++) begin
            wr(6'h17, {6'h20, 2'(s)});
            for (int j = 0; j < 2; j++) begin
                @(posedge clk_in);
                sense_in.bemf_level <= TH[s] - 10'h001 + 10'(j);
                settle();
                chk(bemf_fault_out, s != 0 && j == 0);
            end
        end
        seed = lfsr(seed);
        wr(6'h17, {seed[5:0] | 6'h01, 2'h0});
        for (int j = 0; j < 2; j++) begin
            @(posedge clk_in);
            sense_in.tracking_error <= {seed[5:0] | 6'h01, 2'h0} + 8'(j - 1);
            sense_in.braking <= 1'b1;
            sense_in.brake_level <= 3'h5 + 3'(j);
            sense_in.track_level <= 4'h3 + 4'(j);
            wr(6'h20, 8'h53);
            settle();
            chk(freq_locked_out, j == 0);
            chk(brake_stop_out, j == 0);
            chk(tracking_pause_out, j == 0);
        end
        for (int m = 0; m < 8; m++) begin
            wr(6'h22, 8'(m));
            settle();
            chk(mode_out, m < 5 ? m : 0);
        end
        for (int k = 0; k < 5; k++) begin
            wr(6'h13, {5'h00, DRV[k][19], 2'h0});
            wr(6'h22, {5'h00, DRV[k][18:16]});
            wr(6'h23, DRV[k][15:8]);
            settle();
            chk({24'h0, drive_scale_out}, DRV[k][7:0]);
        end
        for (int t = 0; t < 2; t++) begin
            wr(6'h24, {5'h00, 1'(t), 2'h0});
            settle();
            chk(frame_time0_us_out, t ? 17'h00550 : 17'h01540);
            chk(frame_time3_us_out, t ? 17'h0AA00 : 17'h15400);
        end
        // Finish pass masked, second pass unmasked
        wr(6'h30, 8'h07);
        for (int b = 0; b < 2; b++) begin
            wr(6'h31, {6'h00, 1'(b), 1'b0});
            wr(6'h16, 8'h40);
            wr(6'h22, {4'h1, 1'(b), 3'h3});
            settle();
            chk(state_out, hdcr_pkg::HDCR_ST_PLAYING);
            @(negedge clk_in);
            chk(factor_update_en_out, 1'b0);
            @(posedge clk_in);
            sense_in.playback_done <= 1'b1;
            @(posedge clk_in);
            sense_in.playback_done <= 1'b0;
            settle();
            chk(state_out, b ? 2'h1 : 2'h0);
            chk(factor_update_en_out, 1'b1);
            chk(irq_out, b);
            rd(6'h22);
            chk(q, {28'h0, 1'(b), 3'h3});
            wr(6'h30, 8'h02);
            settle();
            chk(irq_out, 1'b0);
        end
        wr(6'h16, 8'h00);
        wr(6'h22, 8'h13);
        settle();
        chk(factor_update_en_out, 1'b1);
        wr(6'h16, 8'h80);
        settle();
        chk(factor_update_en_out, 1'b0);
        wr(6'h22, 8'h03);
        settle();
        chk(state_out, hdcr_pkg::HDCR_ST_IDLE);
        complete_run();
    end
endmodule : haptic_drive_control_regs_tb
bind hdcr_regs hdcr_props u_props (.*);
